// ### rtl/rsc_pkg.sv
// Constants shared by the reset and strap configuration block.
package rsc_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned RESET_MIN_NS  = 1000;
    localparam int unsigned RESET_MIN_CYC =
        (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned BLINK_NS      = 50_000_000;
    localparam int unsigned BLINK_CYC_DFLT = BLINK_NS / CLK_PERIOD_NS;
    localparam int unsigned RST_CNT_W     = 8;
    localparam int unsigned BLINK_CNT_W   = 24;

    // ------------------------------------------------------------------
    // Strap pin positions and pull defaults
    // ------------------------------------------------------------------
    localparam int unsigned STRAP_W     = 9;
    localparam int unsigned ADDR_W      = 5;
    localparam int unsigned SP_ADDR_LSB = 0;
    localparam int unsigned SP_DUPLEX   = 5;
    localparam int unsigned SP_LEDCFG   = 6;
    localparam int unsigned SP_XOVER    = 7;
    localparam int unsigned SP_RMII     = 8;
    localparam logic [STRAP_W-1:0] STRAP_DEFAULT = 9'h0E1;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam logic [5:0] IDX_ADVERT   = 6'h04;
    localparam logic [5:0] IDX_XCTRL    = 6'h19;
    localparam logic [5:0] IDX_MISC     = 6'h20;
    localparam logic [5:0] IDX_STATUS   = 6'h21;
    localparam logic [5:0] IDX_IRQ_STAT = 6'h22;
    localparam logic [5:0] IDX_IRQ_CLR  = 6'h23;
    localparam logic [5:0] IDX_IRQ_EN   = 6'h24;

    // ------------------------------------------------------------------
    // Register fields and reset values
    // ------------------------------------------------------------------
    localparam logic [15:0] ADVERT_RST_HD   = 16'h00A1;
    localparam logic [15:0] ADVERT_RST_FD   = 16'h01E1;
    localparam logic [15:0] XCTRL_XOVER_MSK = 16'h8000;
    localparam logic [15:0] XCTRL_LED_MSK   = 16'h0020;
    localparam logic [15:0] XCTRL_RST_BASE  = 16'h0000;
    localparam int unsigned XCTRL_XOVER_BIT = 15;
    localparam int unsigned XCTRL_LED_BIT   = 5;
    localparam int unsigned MISC_ROLE_BIT   = 0;
    localparam logic        ROLE_RST        = 1'b0;
    localparam int unsigned IRQ_W           = 2;
    localparam int unsigned IRQ_LINK        = 0;
    localparam int unsigned IRQ_RESET_DONE  = 1;

    function automatic logic [15:0] wb_merge(
        input logic [15:0] old_val,
        input logic [15:0] new_val,
        input logic [1:0]  sel
    );
        wb_merge = {sel[1] ? new_val[15:8] : old_val[15:8],
                    sel[0] ? new_val[7:0]  : old_val[7:0]};
    endfunction

endpackage

// ### rtl/rsc_reset_filter.sv
// Qualifies the external reset pin: it must stay low for the minimum time.
`timescale 1ns/1ps
`default_nettype none
module rsc_reset_filter
    import rsc_pkg::*;
(
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic pin_low_i,
    output logic      hold_o
);

    typedef enum logic [1:0] {F_IDLE, F_COUNT, F_HOLD} rsc_filt_t;

    rsc_filt_t              state_reg;
    rsc_filt_t              state_next;
    logic [RST_CNT_W-1:0]   cnt_reg;
    logic [RST_CNT_W-1:0]   cnt_next;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= F_IDLE;
            cnt_reg   <= '0;
        end else begin
            state_reg <= state_next;
            cnt_reg   <= cnt_next;
        end
    end

    // Glitches shorter than the minimum low time are ignored on purpose.
    always_comb begin
        state_next = state_reg;
        cnt_next   = '0;
        unique case (state_reg)
            F_IDLE: begin
                if (pin_low_i) begin
                    state_next = F_COUNT;
                end
            end
            F_COUNT: begin
                cnt_next = cnt_reg + RST_CNT_W'(1);
                if (!pin_low_i) begin
                    state_next = F_IDLE;
                end else if (cnt_reg == RST_CNT_W'(RESET_MIN_CYC - 2)) begin
                    state_next = F_HOLD;
                end
            end
            F_HOLD: begin
                if (!pin_low_i) begin
                    state_next = F_IDLE;
                end
            end
            default: begin
                state_next = F_IDLE;
            end
        endcase
    end

    assign hold_o = (state_reg == F_HOLD);

endmodule
`default_nettype wire

// ### rtl/rsc_sync.sv
// Two flip-flop synchroniser for pins from outside the clock domain.
`timescale 1ns/1ps
`default_nettype none
module rsc_sync #(
    parameter int unsigned W       = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    input  wire logic         clk_i,
    input  wire logic         rst_i,
    input  wire logic [W-1:0] d_i,
    output logic      [W-1:0] q_o
);

    logic [W-1:0] meta_reg;
    logic [W-1:0] sync_reg;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            meta_reg <= RST_VAL;
            sync_reg <= RST_VAL;
        end else begin
            meta_reg <= d_i;
            sync_reg <= meta_reg;
        end
    end

    assign q_o = sync_reg;

endmodule
`default_nettype wire

// ### rtl/rsc_top.sv
// Reset, strap capture and shared pin control of the transceiver.
// ----------------------------------------------------------------------
// ----------------------------------------------------------------------
`timescale 1ns/1ps
`default_nettype none
module rsc_top
    import rsc_pkg::*;
#(
    parameter int unsigned BLINK_CYCLES = BLINK_CYC_DFLT
) (
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               reset_pin_n_i,
    input  wire logic               wb_cyc_i,
    input  wire logic               wb_stb_i,
    input  wire logic               wb_we_i,
    input  wire logic [7:0]         wb_adr_i,
    input  wire logic [3:0]         wb_sel_i,
    input  wire logic [31:0]        wb_dat_i,
    output logic      [31:0]        wb_dat_o,
    output logic                    wb_ack_o,
    input  wire logic [STRAP_W-1:0] strap_pin_i,
    output logic      [STRAP_W-1:0] strap_pin_o,
    output logic      [STRAP_W-1:0] strap_pin_oe_o,
    input  wire logic [STRAP_W-1:0] func_out_i,
    input  wire logic               link_up_i,
    input  wire logic               activity_i,
    input  wire logic               sleep_pin_i,
    output logic                    sleep_pin_o,
    output logic                    sleep_pin_oe_o,
    output logic      [ADDR_W-1:0]  mgmt_addr_o,
    output logic                    rmii_mode_o,
    output logic                    auto_xover_o,
    output logic                    power_down_o,
    output logic                    irq_o,
    output logic                    in_reset_o
);

    // ------------------------------------------------------------------
    // Pin synchronisers and reset qualification
    // ------------------------------------------------------------------
    logic               reset_pin_n_s;
    logic [STRAP_W-1:0] strap_s;
    logic               sleep_s;
    logic               pin_hold;
    logic               int_rst;

    rsc_sync #(.W(1), .RST_VAL(1'b1)) u_rst_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (reset_pin_n_i),
        .q_o   (reset_pin_n_s)
    );

    // Synchronisers start at the pull defaults of the unfitted straps.
    rsc_sync #(.W(STRAP_W), .RST_VAL(STRAP_DEFAULT)) u_strap_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (strap_pin_i),
        .q_o   (strap_s)
    );

    rsc_sync #(.W(1), .RST_VAL(1'b1)) u_sleep_sync (
        .clk_i (clk_i),
        .rst_i (rst_i),
        .d_i   (sleep_pin_i),
        .q_o   (sleep_s)
    );

    rsc_reset_filter u_filter (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .pin_low_i (~reset_pin_n_s),
        .hold_o    (pin_hold)
    );

    assign int_rst = rst_i | pin_hold;

    // ------------------------------------------------------------------
    // Strap capture
    // ------------------------------------------------------------------
    logic [STRAP_W-1:0] strap_reg;

    // Sampling every reset cycle means the last one before release wins.
    always_ff @(posedge clk_i) begin
        if (int_rst) begin
            strap_reg <= strap_s;
        end
    end

    assign mgmt_addr_o = strap_reg[SP_ADDR_LSB +: ADDR_W];
    assign rmii_mode_o = strap_reg[SP_RMII];

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic [5:0]  bus_idx;
    logic        bus_req;
    logic        wr_en;
    logic        hit_adv;
    logic        hit_xctrl;
    logic        hit_misc;
    logic        hit_stat;
    logic        hit_istat;
    logic        hit_iclr;
    logic        hit_ien;

    assign bus_idx   = wb_adr_i[7:2];
    assign bus_req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    // A write lands at the edge that completes the handshake with ack.
    assign wr_en     = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & ~int_rst;
    assign hit_adv   = (bus_idx == IDX_ADVERT);
    assign hit_xctrl = (bus_idx == IDX_XCTRL);
    assign hit_misc  = (bus_idx == IDX_MISC);
    assign hit_stat  = (bus_idx == IDX_STATUS);
    assign hit_istat = (bus_idx == IDX_IRQ_STAT);
    assign hit_iclr  = (bus_idx == IDX_IRQ_CLR);
    assign hit_ien   = (bus_idx == IDX_IRQ_EN);

    // ------------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------------
    logic [15:0] advert_reg;
    logic [15:0] xctrl_reg;
    logic        role_reg;
    logic [15:0] advert_rst;
    logic [15:0] xctrl_rst;

    assign advert_rst = strap_s[SP_DUPLEX] ? ADVERT_RST_FD
                                           : ADVERT_RST_HD;
    assign xctrl_rst  = XCTRL_RST_BASE
                      | (strap_s[SP_XOVER]  ? XCTRL_XOVER_MSK : 16'h0000)
                      | (strap_s[SP_LEDCFG] ? XCTRL_LED_MSK   : 16'h0000);

    always_ff @(posedge clk_i) begin
        if (int_rst) begin
            advert_reg <= advert_rst;
        end else if (wr_en && hit_adv) begin
            advert_reg <= wb_merge(advert_reg, wb_dat_i[15:0],
                                   wb_sel_i[1:0]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (int_rst) begin
            xctrl_reg <= xctrl_rst;
        end else if (wr_en && hit_xctrl) begin
            xctrl_reg <= wb_merge(xctrl_reg, wb_dat_i[15:0],
                                  wb_sel_i[1:0]);
        end
    end

    always_ff @(posedge clk_i) begin
        if (int_rst) begin
            role_reg <= ROLE_RST;
        end else if (wr_en && hit_misc && wb_sel_i[0]) begin
            role_reg <= wb_dat_i[MISC_ROLE_BIT];
        end
    end

    assign auto_xover_o = xctrl_reg[XCTRL_XOVER_BIT];

    // ------------------------------------------------------------------
    // Events and interrupt status
    // ------------------------------------------------------------------
    logic             link_d_reg;
    logic             int_rst_d_reg;
    logic [IRQ_W-1:0] irq_ev;
    logic [IRQ_W-1:0] irq_clr;
    logic [IRQ_W-1:0] irq_stat_reg;
    logic [IRQ_W-1:0] irq_en_reg;
    logic             irq_pending;

    assign irq_ev[IRQ_LINK]       = link_up_i ^ link_d_reg;
    assign irq_ev[IRQ_RESET_DONE] = int_rst_d_reg & ~int_rst;
    assign irq_clr     = (wr_en && hit_iclr && wb_sel_i[0])
                       ? wb_dat_i[IRQ_W-1:0] : '0;
    assign irq_pending = |(irq_stat_reg & irq_en_reg);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            link_d_reg    <= 1'b0;
            int_rst_d_reg <= 1'b1;
        end else begin
            link_d_reg    <= link_up_i;
            int_rst_d_reg <= int_rst;
        end
    end

    // An event in the clearing cycle survives: set wins over clear.
    always_ff @(posedge clk_i) begin
        if (int_rst) begin
            irq_stat_reg <= '0;
            irq_en_reg   <= '0;
        end else begin
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_ev;
            if (wr_en && hit_ien && wb_sel_i[0]) begin
                irq_en_reg <= wb_dat_i[IRQ_W-1:0];
            end
        end
    end

    // ------------------------------------------------------------------
    // Shared sleep or interrupt pin
    // ------------------------------------------------------------------
    logic sleep_oe_reg;
    logic sleep_lvl_reg;
    logic pd_reg;
    logic irq_reg;

    always_ff @(posedge clk_i) begin
        sleep_oe_reg  <= ~int_rst & role_reg & irq_pending;
        sleep_lvl_reg <= int_rst;
        pd_reg        <= ~int_rst & ~role_reg & ~sleep_s;
        irq_reg       <= ~int_rst & irq_pending;
    end

    assign sleep_pin_oe_o = sleep_oe_reg;
    assign sleep_pin_o    = sleep_lvl_reg;
    assign power_down_o   = pd_reg;
    assign irq_o          = irq_reg;

    // ------------------------------------------------------------------
    // Link indicator and functional pin drive
    // ------------------------------------------------------------------
    logic [BLINK_CNT_W-1:0] blink_cnt_reg;
    logic                   blink_reg;
    logic                   blink_tick;
    logic                   led_val;
    logic [STRAP_W-1:0]     pin_func;
    logic [STRAP_W-1:0]     pin_o_reg;
    logic [STRAP_W-1:0]     pin_oe_reg;
    logic                   in_rst_reg;

    assign blink_tick =
        (blink_cnt_reg == BLINK_CNT_W'(BLINK_CYCLES - 1));

    always_ff @(posedge clk_i) begin
        if (int_rst || blink_tick) begin
            blink_cnt_reg <= '0;
        end else begin
            blink_cnt_reg <= blink_cnt_reg + BLINK_CNT_W'(1);
        end
    end

    always_ff @(posedge clk_i) begin
        if (int_rst) begin
            blink_reg <= 1'b0;
        end else if (blink_tick) begin
            blink_reg <= ~blink_reg;
        end
    end

    // Mode 1 shows link only; mode 2 also blinks on activity.
    assign led_val = link_up_i
                   & ~(~xctrl_reg[XCTRL_LED_BIT] & activity_i
                       & blink_reg);

    genvar gi;
    generate
        for (gi = 0; gi < STRAP_W; gi++) begin : g_pin
            assign pin_func[gi] = (gi == SP_DUPLEX) ? led_val
                                                    : func_out_i[gi];
        end
    endgenerate

    always_ff @(posedge clk_i) begin
        if (int_rst) begin
            pin_oe_reg <= '0;
            pin_o_reg  <= '0;
        end else begin
            pin_oe_reg <= '1;
            pin_o_reg  <= pin_func;
        end
        in_rst_reg <= int_rst;
    end

    assign strap_pin_oe_o = pin_oe_reg;
    assign strap_pin_o    = pin_o_reg;
    assign in_reset_o     = in_rst_reg;

    // ------------------------------------------------------------------
    // Bus read and acknowledge
    // ------------------------------------------------------------------
    logic [15:0] rd_val;
    logic [15:0] stat_word;
    logic [31:0] dat_reg;
    logic        ack_reg;

    assign stat_word = {7'h00, strap_reg[SP_DUPLEX], pd_reg,
                        strap_reg[SP_RMII], 1'b0,
                        strap_reg[SP_ADDR_LSB +: ADDR_W]};
    assign rd_val = hit_adv   ? advert_reg
                  : hit_xctrl ? xctrl_reg
                  : hit_misc  ? {15'h0000, role_reg}
                  : hit_stat  ? stat_word
                  : hit_istat ? {14'h0000, irq_stat_reg}
                  : hit_ien   ? {14'h0000, irq_en_reg}
                  : 16'h0000;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            dat_reg <= '0;
        end else begin
            ack_reg <= bus_req;
            if (bus_req) begin
                dat_reg <= {16'h0000, rd_val};
            end
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = dat_reg;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    logic [STRAP_W-1:0] strap_last;

    always_ff @(posedge clk_i) begin
        strap_last <= strap_s;
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_reset_release;
        int_rst ##1 !int_rst;
    endsequence

    sequence s_running;
        !int_rst ##1 !int_rst;
    endsequence

    a_pins_hiz: assert property (
        int_rst |=> (strap_pin_oe_o == '0) && !sleep_pin_oe_o)
        else $error("shared pins driven during reset");
    a_pins_resume: assert property (
        s_reset_release |=> (&strap_pin_oe_o))
        else $error("strap pins not driven after reset");
    a_addr_capture: assert property (
        s_reset_release |->
            mgmt_addr_o == strap_last[SP_ADDR_LSB +: ADDR_W])
        else $error("address strap not latched at release");
    a_strap_frozen: assert property (
        s_running |-> $stable(strap_reg))
        else $error("strap levels changed after reset");
    a_iface_mode: assert property (
        s_reset_release |-> rmii_mode_o == strap_last[SP_RMII])
        else $error("interface mode not taken from strap");
    a_xover_strap: assert property (
        s_reset_release |-> auto_xover_o == strap_last[SP_XOVER])
        else $error("crossover not taken from strap");
    a_advert_load: assert property (
        s_reset_release |-> advert_reg == (strap_last[SP_DUPLEX]
            ? ADVERT_RST_FD : ADVERT_RST_HD))
        else $error("advertisement not loaded from duplex strap");
    a_led_strap: assert property (
        s_reset_release |->
            xctrl_reg[XCTRL_LED_BIT] == strap_last[SP_LEDCFG])
        else $error("indicator mode not taken from strap");
    a_role_default: assert property (
        s_reset_release |-> !role_reg && irq_en_reg == '0
            && irq_stat_reg == '0)
        else $error("registers not initialised by reset");
    a_sleep_entry: assert property (
        !role_reg && !sleep_s && !int_rst |=> power_down_o)
        else $error("sleep pin low did not power down");
    a_irq_drive: assert property (
        role_reg && irq_pending && !int_rst |=>
            sleep_pin_oe_o && !sleep_pin_o)
        else $error("interrupt pin not pulled low");
    a_irq_release: assert property (
        !irq_pending |=> !sleep_pin_oe_o)
        else $error("interrupt pin driven with nothing pending");

endmodule
`default_nettype wire

// ### tb/rsc_board.sv
// Board strap resistors and the pull-up on the shared sleep pin.
`timescale 1ns/1ps
`default_nettype none
module rsc_board
    import rsc_pkg::*;
(
    input  wire logic [STRAP_W-1:0] oe_i,
    input  wire logic [STRAP_W-1:0] drv_i,
    input  wire logic [STRAP_W-1:0] res_i,
    input  wire logic               sleep_oe_i,
    input  wire logic               sleep_drv_i,
    input  wire logic               hold_low_i,
    output logic      [STRAP_W-1:0] pin_o,
    output logic                    sleep_o
);
    // Released straps settle to the fitted resistor or the pull default.
    assign pin_o   = (oe_i & drv_i) | (~oe_i & res_i);
    // Open drain: either party pulls low, otherwise the pull-up wins.
    assign sleep_o = ~((sleep_oe_i & ~sleep_drv_i) | hold_low_i);
endmodule
`default_nettype wire

// ### tb/rsc_top_tb_top.sv
// Self-checking bench for the reset and strap configuration block.
`timescale 1ns/1ps
`default_nettype none
module rsc_top_tb_top
    import rsc_pkg::*;
;
    logic               clk_i = 0, rst_i = 1, rpn = 1, cyc = 0, stb = 0;
    logic               we = 0, link = 0, act = 0, hold_low = 0;
    logic [7:0]         adr = 0;
    logic [31:0]        dat = 0, rdat;
    logic               ack, sl_in, sl_o, sl_oe, rmii, xov, pd, irq, inr;
    logic [STRAP_W-1:0] sp_in, sp_o, sp_oe, res = STRAP_DEFAULT, fo = 0;
    logic [ADDR_W-1:0]  addr;
    logic [31:0]        exp_q[$];
    logic [31:0]        seed = 32'h1ef659b7;
    int                 failures = 0, comparisons = 0;

    always #2.5 clk_i = ~clk_i;

    rsc_top #(.BLINK_CYCLES(4)) uut (.clk_i(clk_i), .rst_i(rst_i),
        .reset_pin_n_i(rpn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h3), .wb_dat_i(dat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .strap_pin_i(sp_in), .strap_pin_o(sp_o),
        .strap_pin_oe_o(sp_oe), .func_out_i(fo), .link_up_i(link),
        .activity_i(act), .sleep_pin_i(sl_in), .sleep_pin_o(sl_o),
        .sleep_pin_oe_o(sl_oe), .mgmt_addr_o(addr), .rmii_mode_o(rmii),
        .auto_xover_o(xov), .power_down_o(pd), .irq_o(irq),
        .in_reset_o(inr));

    rsc_board board (.oe_i(sp_oe), .drv_i(sp_o), .res_i(res),
        .sleep_oe_i(sl_oe), .sleep_drv_i(sl_o), .hold_low_i(hold_low),
        .pin_o(sp_in), .sleep_o(sl_in));

    task automatic chk(input string nm, input logic [31:0] s, e);
        comparisons++;
        if (s !== e) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [15:0] d);
        @(posedge clk_i);
        cyc <= 1;
        stb <= 1;
        we  <= w;
        adr <= a;
        dat <= {16'h0000, d};
        if (!w) exp_q.push_back({16'h0000, d});
        do @(posedge clk_i); while (ack !== 1'b1);
        cyc <= 0;
        stb <= 0;
    endtask

    // Read data is judged against the oldest note at each read answer.
    always @(posedge clk_i) begin
        if (ack === 1'b1 && cyc && !we) begin
            if (exp_q.size() == 0) chk("read note", 32'h1, 32'h0);
            else chk("read data", rdat, exp_q.pop_front());
        end
    end

    // Strap capture is judged from the resistor levels fitted.
    // The fitted levels are passed in, so a later change of res is moot.
    task automatic chk_cfg(input logic [STRAP_W-1:0] r);
        chk("addr", addr, r[4:0]);
        chk("rmii", rmii, r[8]);
        chk("xover", xov, r[7]);
        wb(0, 8'h10, r[5] ? 16'h01E1 : 16'h00A1);
        wb(0, 8'h64, {r[7], 9'h000, r[6], 5'h00});
        wb(0, 8'h84, {7'h00, r[5], 1'b0, r[8], 1'b0, r[4:0]});
    endtask

    // Counts lit cycles of the link indicator over eight edges.
    task automatic chk_led(input string nm, input int e);
        int n;
        n = 0;
        repeat (8) begin
            @(posedge clk_i);
            n += sp_o[5];
        end
        chk(nm, n, e);
    endtask

    task automatic end_sim();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial begin
        repeat (20000) @(posedge clk_i);
        failures++;
        end_sim();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk_i);
        rst_i <= 0;
        repeat (6) @(posedge clk_i);
        chk_cfg(res);
        fo <= $random(seed);
        for (int i = 0; i < 3; i++) begin
            res <= $random(seed);
            wb(1, 8'h64, 16'h0000);
            rpn <= 0;
            repeat (220) @(posedge clk_i);
            chk("oe in reset", sp_oe, 9'h000);
            chk("in reset", {inr, sl_o, sl_oe}, 3'b110);
            rpn <= 1;
            repeat (8) @(posedge clk_i);
            chk("oe after", sp_oe, 9'h1FF);
            chk("pin out", sp_o[4:0], fo[4:0]);
            res <= ~res;
            chk_cfg(res);
            res <= ~res;
        end
        rpn <= 0;
        repeat (100) @(posedge clk_i);
        rpn <= 1;
        chk("short pulse", inr, 1'b0);
        hold_low <= 1;
        repeat (5) @(posedge clk_i);
        chk("power down", pd, 1'b1);
        hold_low <= 0;
        wb(1, 8'h8C, 16'h0003);
        wb(1, 8'h90, 16'h0001);
        wb(1, 8'h80, 16'h0001);
        link <= 1;
        repeat (4) @(posedge clk_i);
        chk("irq", irq, 1'b1);
        chk("irq pin", {sl_oe, sl_in}, 2'b10);
        wb(0, 8'h88, 16'h0001);
        wb(1, 8'h90, 16'h0000);
        repeat (3) @(posedge clk_i);
        chk("masked", {irq, sl_in}, 2'b01);
        wb(1, 8'h90, 16'h0001);
        wb(1, 8'h8C, 16'h0001);
        repeat (3) @(posedge clk_i);
        chk("cleared", {irq, pd}, 2'b00);
        act <= 1;
        wb(1, 8'h64, 16'h0020);
        repeat (2) @(posedge clk_i);
        chk_led("mode one", 8);
        wb(1, 8'h64, 16'h0000);
        repeat (2) @(posedge clk_i);
        chk_led("mode two", 4);
        wb(0, 8'h8C, 16'h0000);
        wb(0, 8'hFC, 16'h0000);
        repeat (4) @(posedge clk_i);
        end_sim();
    end
endmodule
`default_nettype wire
